// ===== verilog/sgm_pkg.sv
// constants for the sgmii management register bank
`default_nettype none
package sgm_pkg;

    // register addresses on the management bus
    localparam logic [4:0] ADDR_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h01;
    localparam logic [4:0] ADDR_ID_HI = 5'h02;
    localparam logic [4:0] ADDR_ID_LO = 5'h03;
    localparam logic [4:0] ADDR_AN_FIRST = 5'h04;
    localparam logic [4:0] ADDR_AN_LAST = 5'h08;
    localparam logic [4:0] ADDR_EXT_STATUS = 5'h0F;
    localparam logic [4:0] ADDR_AN_INT_CTRL = 5'h10;

    // link_control bit positions
    localparam int CTRL_RESET = 15;
    localparam int CTRL_LOOPBACK = 14;
    localparam int CTRL_SPEED_LSB = 13;
    localparam int CTRL_AN_ENABLE = 12;
    localparam int CTRL_POWER_DOWN = 11;
    localparam int CTRL_ISOLATE = 10;
    localparam int CTRL_AN_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int CTRL_COL_TEST = 7;
    localparam int CTRL_SPEED_MSB = 6;
    localparam int CTRL_UNIDIR = 5;

    // link_control masks and default
    localparam logic [15:0] CTRL_DEFAULT = 16'h1540;
    localparam logic [15:0] CTRL_WMASK_BASE = 16'hDE20;
    localparam logic [15:0] CTRL_WMASK_SPEED = 16'h2040;
    localparam logic [15:0] CTRL_FIXED_DUPLEX = 16'h0100;
    localparam logic [15:0] CTRL_FIXED_SPEED_MSB = 16'h0040;
    localparam logic [15:0] CTRL_SELF_CLEAR = 16'h0200;

    // status register layout
    localparam logic [15:0] STATUS_FIXED = 16'h01C8;
    localparam logic [15:0] STATUS_AN_DONE = 16'h0020;
    localparam logic [15:0] STATUS_LINK = 16'h0004;

    // extended_ability_status: full-duplex 1000BASE-X only
    localparam logic [15:0] EXT_STATUS_VALUE = 16'h8000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // management frame fields
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [3:0] HDR_LAST = 4'hB;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [4:0] SKIP_LAST = 5'h11;

    typedef enum logic [2:0] {
        MS_IDLE = 3'b000,
        MS_HDR = 3'b001,
        MS_TA = 3'b010,
        MS_RDATA = 3'b011,
        MS_WDATA = 3'b100,
        MS_SKIP = 3'b101
    } sgm_mdio_state_type;

endpackage : sgm_pkg
`default_nettype wire

// ===== verilog/sgm_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module sgm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLK, // system clock
    input wire logic RST, // async reset, active high
    input wire logic [WIDTH-1:0] D, // asynchronous inputs
    output logic [WIDTH-1:0] Q // synchronised outputs
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            meta_q <= '0;
            Q <= '0;
        end else begin
            meta_q <= D;
            Q <= meta_q;
        end
    end

endmodule : sgm_sync
`default_nettype wire

// ===== verilog/sgm_mgmt_regs.sv
// sgmii management register bank with serial management slave
`timescale 1ns/1ns
`default_nettype none
module sgm_mgmt_regs #(
    parameter bit PS_MAC_MODE = 1'b0, // speed bits writable
    parameter bit TBI_BUILD = 1'b0, // ten-bit interface build
    parameter bit RATE_2G5 = 1'b0, // single-speed 2.5G build
    parameter logic [15:0] ID_WORD_HI = 16'h0A5C, // arbitrary value
    parameter logic [15:0] ID_WORD_LO = 16'h3C10 // arbitrary value
) (
    input wire logic CLK, // 125 MHz clock
    input wire logic RST, // async core reset, active high
    input wire logic CLOCK_MANAGER_LOCKED, // lock pin, async
    input wire logic MDC, // management clock pin
    input wire logic MDIO_IN, // management data pin level
    output logic MDIO_OUT, // management data driven value
    output logic MDIO_OE, // high while driving management data
    input wire logic [4:0] PHY_ADDRESS, // this port's address
    input wire logic [15:0] CONFIG_VECTOR, // parallel control image
    input wire logic CONFIG_VALID, // load config vector strobe
    input wire logic LINK_UP, // current link state
    input wire logic AN_COMPLETE, // auto-negotiation done
    output logic CORE_RESET, // soft reset pulse
    output logic INTERNAL_LOOPBACK, // transceiver loopback
    output logic EXT_LOOPBACK_REQ, // external pma loopback
    output logic POWER_DOWN, // transceiver low power
    output logic ISOLATE, // isolate from gmii
    output logic AN_ENABLE, // auto-negotiation enable
    output logic AN_RESTART, // restart pulse
    output logic UNIDIR_ENABLE, // transmit regardless of link
    output logic [1:0] SPEED_SEL // {msb, lsb} speed selection
);

    // speed bits writable only in ps mac mode and not in 2.5G build
    localparam bit SPEED_RW = PS_MAC_MODE && !RATE_2G5;

    logic [2:0] sync_out;
    logic mdc_s;
    logic mdio_s;
    logic locked_s;
    logic mdc_prev_q;
    logic mdc_rise;

    // pins cross into the clock domain through two flops
    sgm_sync #(
        .WIDTH(3)
    ) u_sync (
        .CLK(CLK),
        .RST(RST),
        .D({MDC, MDIO_IN, CLOCK_MANAGER_LOCKED}),
        .Q(sync_out)
    );

    assign mdc_s = sync_out[2];
    assign mdio_s = sync_out[1];
    assign locked_s = sync_out[0];
    // mdc edge found on synchronised levels, idle low
    assign mdc_rise = mdc_s & ~mdc_prev_q;

    // control write with masks; power down only sets here
    function automatic logic [15:0] ctrl_apply(
        input logic [15:0] cur,
        input logic [15:0] val
    );
        logic [15:0] wmask;
        logic [15:0] res;
        wmask = sgm_pkg::CTRL_WMASK_BASE;
        if (SPEED_RW) begin
            wmask = wmask | sgm_pkg::CTRL_WMASK_SPEED;
        end
        res = (val & wmask) | sgm_pkg::CTRL_FIXED_DUPLEX;
        if (!SPEED_RW) begin
            res = res | sgm_pkg::CTRL_FIXED_SPEED_MSB;
        end
        res[sgm_pkg::CTRL_POWER_DOWN] = cur[sgm_pkg::CTRL_POWER_DOWN] |
            val[sgm_pkg::CTRL_POWER_DOWN];
        return res;
    endfunction : ctrl_apply

    // frame engine state
    sgm_pkg::sgm_mdio_state_type state_q;
    logic [4:0] cnt_q;
    logic [11:0] hdr_q;
    logic bit_prev_q;
    logic [15:0] rd_shift_q;
    logic [15:0] wr_shift_q;
    logic rd_stb_q;
    logic wr_stb_q;
    logic [4:0] acc_addr_q;

    // register state
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic link_q;
    logic link_d;
    logic reg_reset;

    // frame header fields
    wire [1:0] hdr_op = hdr_q[11:10];
    wire [4:0] hdr_reg = hdr_q[4:0];
    // decisions on the last header bit use the bit now arriving
    wire [11:0] hdr_next = {hdr_q[10:0], mdio_s};
    wire hdr_read = hdr_next[11:10] == sgm_pkg::OP_READ;
    wire hdr_write = hdr_next[11:10] == sgm_pkg::OP_WRITE;
    wire hdr_match = hdr_next[9:5] == PHY_ADDRESS;
    wire is_read = hdr_op == sgm_pkg::OP_READ;

    // address decode
    wire sel_ctrl = hdr_reg == sgm_pkg::ADDR_CONTROL;
    wire sel_status = hdr_reg == sgm_pkg::ADDR_STATUS;
    wire sel_id_hi = hdr_reg == sgm_pkg::ADDR_ID_HI;
    wire sel_id_lo = hdr_reg == sgm_pkg::ADDR_ID_LO;
    wire sel_ext = hdr_reg == sgm_pkg::ADDR_EXT_STATUS;

    // status word built from live inputs and the link latch
    wire [15:0] status_word = sgm_pkg::STATUS_FIXED |
        (AN_COMPLETE ? sgm_pkg::STATUS_AN_DONE : sgm_pkg::READ_ZERO) |
        (link_q ? sgm_pkg::STATUS_LINK : sgm_pkg::READ_ZERO);

    // an registers 4..8 and 16 hold no contents in this bank
    wire [15:0] rd_mux =
        sel_ctrl ? ctrl_q :
        sel_status ? status_word :
        sel_id_hi ? ID_WORD_HI :
        sel_id_lo ? ID_WORD_LO :
        sel_ext ? sgm_pkg::EXT_STATUS_VALUE :
        sgm_pkg::READ_ZERO;

    // serial management frame engine
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mdc_prev_q <= 1'b0;
            state_q <= sgm_pkg::MS_IDLE;
            cnt_q <= 5'h00;
            hdr_q <= 12'h000;
            bit_prev_q <= 1'b1;
            rd_shift_q <= 16'h0000;
            wr_shift_q <= 16'h0000;
            rd_stb_q <= 1'b0;
            wr_stb_q <= 1'b0;
            acc_addr_q <= 5'h00;
            MDIO_OUT <= 1'b0;
            MDIO_OE <= 1'b0;
        end else begin
            mdc_prev_q <= mdc_s;
            rd_stb_q <= 1'b0;
            wr_stb_q <= 1'b0;
            if (mdc_rise) begin
                bit_prev_q <= mdio_s;
                case (state_q)
                    sgm_pkg::MS_IDLE: begin
                        // start of frame is a 0 then a 1
                        if (!bit_prev_q && mdio_s) begin
                            state_q <= sgm_pkg::MS_HDR;
                            cnt_q <= 5'h00;
                        end
                    end
                    sgm_pkg::MS_HDR: begin
                        hdr_q <= hdr_next;
                        cnt_q <= cnt_q + 5'h01;
                        // twelfth header bit: pick turnaround or skip
                        if (cnt_q[3:0] == sgm_pkg::HDR_LAST) begin
                            cnt_q <= 5'h00;
                            acc_addr_q <= hdr_next[4:0];
                            if ((hdr_read || hdr_write) && hdr_match) begin
                                state_q <= sgm_pkg::MS_TA;
                            end else begin
                                state_q <= sgm_pkg::MS_SKIP;
                            end
                        end
                    end
                    sgm_pkg::MS_TA: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'h00) begin
                            if (is_read) begin
                                MDIO_OE <= 1'b1;
                                MDIO_OUT <= 1'b0;
                                // word frozen here so later changes cannot tear it
                                rd_shift_q <= rd_mux;
                                rd_stb_q <= 1'b1;
                            end
                        end else begin
                            cnt_q <= 5'h00;
                            if (is_read) begin
                                MDIO_OUT <= rd_shift_q[15];
                                rd_shift_q <= {rd_shift_q[14:0], 1'b0};
                                state_q <= sgm_pkg::MS_RDATA;
                            end else begin
                                state_q <= sgm_pkg::MS_WDATA;
                            end
                        end
                    end
                    sgm_pkg::MS_RDATA: begin
                        cnt_q <= cnt_q + 5'h01;
                        // last data bit has been shown; release the wire
                        if (cnt_q == sgm_pkg::DATA_LAST) begin
                            MDIO_OE <= 1'b0;
                            bit_prev_q <= 1'b1;
                            state_q <= sgm_pkg::MS_IDLE;
                        end else begin
                            MDIO_OUT <= rd_shift_q[15];
                            rd_shift_q <= {rd_shift_q[14:0], 1'b0};
                        end
                    end
                    sgm_pkg::MS_WDATA: begin
                        cnt_q <= cnt_q + 5'h01;
                        wr_shift_q <= {wr_shift_q[14:0], mdio_s};
                        if (cnt_q == sgm_pkg::DATA_LAST) begin
                            // commit after the sixteenth data bit
                            wr_stb_q <= 1'b1;
                            bit_prev_q <= 1'b1;
                            state_q <= sgm_pkg::MS_IDLE;
                        end
                    end
                    sgm_pkg::MS_SKIP: begin
                        // sit out a frame meant for another port
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == sgm_pkg::SKIP_LAST) begin
                            bit_prev_q <= 1'b1;
                            state_q <= sgm_pkg::MS_IDLE;
                        end
                    end
                    default: begin
                        MDIO_OE <= 1'b0;
                        state_q <= sgm_pkg::MS_IDLE;
                    end
                endcase
            end
        end
    end

    // register updates
    wire mdio_ctrl_wr = wr_stb_q &&
        acc_addr_q == sgm_pkg::ADDR_CONTROL;
    wire status_rd = rd_stb_q &&
        acc_addr_q == sgm_pkg::ADDR_STATUS;

    // lock loss and soft reset restore defaults; frames keep running
    assign reg_reset = ctrl_q[sgm_pkg::CTRL_RESET] | ~locked_s;

    // management write first, then config vector, else restart drops
    assign ctrl_d =
        mdio_ctrl_wr ? ctrl_apply(ctrl_q, wr_shift_q) :
        CONFIG_VALID ? ctrl_apply(ctrl_q, CONFIG_VECTOR) :
        ctrl_q & ~sgm_pkg::CTRL_SELF_CLEAR;

    // any drop clears the latch, a status read reloads it
    assign link_d = status_rd ? LINK_UP : (link_q & LINK_UP);

    // register bank state, held at defaults by any reset cause
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= sgm_pkg::CTRL_DEFAULT;
            link_q <= 1'b0;
        end else if (reg_reset) begin
            ctrl_q <= sgm_pkg::CTRL_DEFAULT;
            link_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            link_q <= link_d;
        end
    end

    // control outputs
    assign CORE_RESET = ctrl_q[sgm_pkg::CTRL_RESET];
    assign INTERNAL_LOOPBACK = !TBI_BUILD &&
        ctrl_q[sgm_pkg::CTRL_LOOPBACK];
    assign EXT_LOOPBACK_REQ = TBI_BUILD &&
        ctrl_q[sgm_pkg::CTRL_LOOPBACK];
    assign POWER_DOWN = !TBI_BUILD &&
        ctrl_q[sgm_pkg::CTRL_POWER_DOWN];
    assign ISOLATE = ctrl_q[sgm_pkg::CTRL_ISOLATE];
    assign AN_ENABLE = ctrl_q[sgm_pkg::CTRL_AN_ENABLE];
    assign AN_RESTART = ctrl_q[sgm_pkg::CTRL_AN_RESTART];
    assign UNIDIR_ENABLE = ctrl_q[sgm_pkg::CTRL_UNIDIR] &&
        !ctrl_q[sgm_pkg::CTRL_AN_ENABLE];
    assign SPEED_SEL = {ctrl_q[sgm_pkg::CTRL_SPEED_MSB],
        ctrl_q[sgm_pkg::CTRL_SPEED_LSB]};

endmodule : sgm_mgmt_regs
`default_nettype wire

// ===== bench/sgm_mgmt_regs_assertions.sv
// concurrent checks on the control outputs of the register bank
`timescale 1ns/1ns
`default_nettype none
module sgm_mgmt_regs_assertions #(
    parameter bit PS_MAC_MODE = 1'h0, // speed bits writable
    parameter bit TBI_BUILD = 1'h0 // ten-bit interface build
) (
    input wire logic CLK, // clock
    input wire logic RST, // async reset
    input wire logic CLOCK_MANAGER_LOCKED, // lock pin
    input wire logic [15:0] CONFIG_VECTOR, // control image
    input wire logic CONFIG_VALID, // image strobe
    input wire logic CORE_RESET, // soft reset pulse
    input wire logic INTERNAL_LOOPBACK, // loopback
    input wire logic EXT_LOOPBACK_REQ, // external loopback
    input wire logic POWER_DOWN, // low power
    input wire logic ISOLATE, // isolate
    input wire logic AN_ENABLE, // an enable
    input wire logic AN_RESTART, // restart pulse
    input wire logic UNIDIR_ENABLE, // unidirectional
    input wire logic [1:0] SPEED_SEL // speed pair
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence lock_lost;
        !CLOCK_MANAGER_LOCKED [*4];
    endsequence
    sequence dflt_seen;
        ISOLATE && AN_ENABLE && !POWER_DOWN && !UNIDIR_ENABLE;
    endsequence

    chk_lock_defaults: assert property (lock_lost |-> dflt_seen)
        else $error("outputs not at default after lock loss");
    chk_soft_reset: assert property (CORE_RESET |=>
        (!CORE_RESET && SPEED_SEL == 2'h2) and dflt_seen)
        else $error("soft reset did not restore defaults");
    chk_restart_pulse: assert property (AN_RESTART |=> !AN_RESTART)
        else $error("restart did not clear itself");
    chk_power_sticky: assert property ($fell(POWER_DOWN) |->
        $past(CORE_RESET) || !$past(CLOCK_MANAGER_LOCKED, 2)
        || !$past(CLOCK_MANAGER_LOCKED, 3) || !$past(CLOCK_MANAGER_LOCKED, 4))
        else $error("power down cleared without reset");
    chk_unidir_gate: assert property (UNIDIR_ENABLE |-> !AN_ENABLE)
        else $error("unidirectional while an enabled");
    chk_speed_fixed: assert property (PS_MAC_MODE || SPEED_SEL == 2'h2)
        else $error("speed bits not fixed at 1000");
    chk_loop_route: assert property (TBI_BUILD ? !INTERNAL_LOOPBACK
        : !EXT_LOOPBACK_REQ)
        else $error("loopback on wrong output");
    chk_tbi_power: assert property (!TBI_BUILD || !POWER_DOWN)
        else $error("power down active in ten-bit build");
    property cfg_load;
        (CONFIG_VALID && !CONFIG_VECTOR[15] && !CORE_RESET
            && $past(CLOCK_MANAGER_LOCKED, 2) && !$past(RST)
            && !$past(RST, 2)) |=>
            (ISOLATE == $past(CONFIG_VECTOR[10])
            && AN_ENABLE == $past(CONFIG_VECTOR[12])
            && UNIDIR_ENABLE == ($past(CONFIG_VECTOR[5])
            && !$past(CONFIG_VECTOR[12])));
    endproperty
    chk_config_load: assert property (cfg_load)
        else $error("config vector not loaded");
endmodule : sgm_mgmt_regs_assertions

bind sgm_mgmt_regs sgm_mgmt_regs_assertions #(.PS_MAC_MODE(PS_MAC_MODE),
    .TBI_BUILD(TBI_BUILD)) i_sgm_mgmt_regs_assertions (.CLK(CLK), .RST(RST),
    .CLOCK_MANAGER_LOCKED(CLOCK_MANAGER_LOCKED),
    .CONFIG_VECTOR(CONFIG_VECTOR), .CONFIG_VALID(CONFIG_VALID),
    .CORE_RESET(CORE_RESET), .INTERNAL_LOOPBACK(INTERNAL_LOOPBACK),
    .EXT_LOOPBACK_REQ(EXT_LOOPBACK_REQ), .POWER_DOWN(POWER_DOWN),
    .ISOLATE(ISOLATE), .AN_ENABLE(AN_ENABLE), .AN_RESTART(AN_RESTART),
    .UNIDIR_ENABLE(UNIDIR_ENABLE), .SPEED_SEL(SPEED_SEL));
`default_nettype wire

// ===== bench/sgm_mdio_host.sv
// station manager model sending management frames
`timescale 1ns/1ns
`default_nettype none
module sgm_mdio_host (
    input wire logic clk, // bench clock
    output var logic mdc, // management clock
    output logic mdio_level, // resolved data wire
    input wire logic dev_out, // device data value
    input wire logic dev_oe // device drives wire
);
    logic host_oe = 1'h0;
    logic host_bit = 1'h1;
    initial mdc = 1'h0;
    // pull-up holds the wire high when nobody drives
    assign mdio_level = dev_oe ? dev_out : (host_oe ? host_bit : 1'h1);

    // two preamble ones, then a whole frame; released from turnaround on read
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [33:0] bits;
        bits = {4'hD, op, phy, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int k = 33; k >= 0; k--) begin
            @(negedge clk);
            mdc = 1'h0;
            host_oe = !(op == sgm_pkg::OP_READ && k < 18);
            host_bit = bits[k];
            repeat (10) @(negedge clk);
            rd = {rd[14:0], mdio_level};
            mdc = 1'h1;
            repeat (9) @(negedge clk);
        end
        host_oe = 1'h0;
    endtask : frame
endmodule : sgm_mdio_host
`default_nettype wire

// ===== bench/sgm_mgmt_regs_tb.sv
// self-checking bench for the management register bank
`timescale 1ns/1ns
`default_nettype none
module sgm_mgmt_regs_tb;
    localparam logic [4:0] PHY = 5'h05;
    localparam logic [4:0] PHY2 = 5'h06;
    localparam logic [15:0] ID_HI = 16'h2B71; // arbitrary value
    localparam logic [15:0] ID_LO = 16'h904E; // arbitrary value
    logic clk;
    logic rst = 1'h1;
    logic locked = 1'h1;
    logic cfg_valid = 1'h0;
    logic link_up = 1'h0;
    logic an_complete = 1'h0;
    logic [15:0] cfg_vector = 16'h0000;
    logic mdc, mdio_level, mdio_out, mdio_oe, core_reset, int_loop, ext_loop;
    logic power_down, isolate, an_enable, an_restart, unidir;
    logic [1:0] speed_sel;
    logic [15:0] outs;
    logic mdio_out2, mdio_oe2, core_reset2, int_loop2, ext_loop2;
    logic power_down2, isolate2, an_enable2, an_restart2, unidir2;
    logic [1:0] speed_sel2;
    logic [15:0] outs2;
    logic [4:0] phy_sel = PHY;
    logic [4:0] unmapped [8] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h10,
        5'h09, 5'h1F};
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    assign outs = {6'h00, core_reset, int_loop, ext_loop, power_down, isolate,
        an_enable, an_restart, unidir, speed_sel};
    assign outs2 = {6'h00, core_reset2, int_loop2, ext_loop2, power_down2,
        isolate2, an_enable2, an_restart2, unidir2, speed_sel2};

    sgm_mgmt_regs #(.ID_WORD_HI(ID_HI), .ID_WORD_LO(ID_LO)) i_sgm_mgmt_regs (
        .CLK(clk), .RST(rst), .CLOCK_MANAGER_LOCKED(locked), .MDC(mdc),
        .MDIO_IN(mdio_level), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe),
        .PHY_ADDRESS(PHY), .CONFIG_VECTOR(cfg_vector),
        .CONFIG_VALID(cfg_valid), .LINK_UP(link_up),
        .AN_COMPLETE(an_complete), .CORE_RESET(core_reset),
        .INTERNAL_LOOPBACK(int_loop), .EXT_LOOPBACK_REQ(ext_loop),
        .POWER_DOWN(power_down), .ISOLATE(isolate), .AN_ENABLE(an_enable),
        .AN_RESTART(an_restart), .UNIDIR_ENABLE(unidir),
        .SPEED_SEL(speed_sel));
    sgm_mgmt_regs #(.PS_MAC_MODE(1'h1), .TBI_BUILD(1'h1), .ID_WORD_HI(ID_HI),
        .ID_WORD_LO(ID_LO)) i_sgm_mgmt_regs_ps (
        .CLK(clk), .RST(rst), .CLOCK_MANAGER_LOCKED(locked), .MDC(mdc),
        .MDIO_IN(mdio_level), .MDIO_OUT(mdio_out2), .MDIO_OE(mdio_oe2),
        .PHY_ADDRESS(PHY2), .CONFIG_VECTOR(cfg_vector),
        .CONFIG_VALID(cfg_valid), .LINK_UP(link_up),
        .AN_COMPLETE(an_complete), .CORE_RESET(core_reset2),
        .INTERNAL_LOOPBACK(int_loop2), .EXT_LOOPBACK_REQ(ext_loop2),
        .POWER_DOWN(power_down2), .ISOLATE(isolate2), .AN_ENABLE(an_enable2),
        .AN_RESTART(an_restart2), .UNIDIR_ENABLE(unidir2),
        .SPEED_SEL(speed_sel2));
    sgm_mdio_host i_sgm_mdio_host (.clk(clk), .mdc(mdc),
        .mdio_level(mdio_level), .dev_out(mdio_oe ? mdio_out : mdio_out2),
        .dev_oe(mdio_oe | mdio_oe2));

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_sgm_mdio_host.frame(sgm_pkg::OP_READ, phy_sel, a, 16'h0000, d);
        chk($sformatf("register %0d", a), exp, d);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        logic [15:0] d;
        i_sgm_mdio_host.frame(sgm_pkg::OP_WRITE, phy_sel, a, v, d);
    endtask : wr

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            mismatches++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'h0;
        repeat (8) @(negedge clk);
        rd(sgm_pkg::ADDR_CONTROL, 16'h1540);
        chk("outputs", 16'h0032, outs);
        rd(sgm_pkg::ADDR_EXT_STATUS, 16'h8000);
        $display("test defaults done");
        wr(sgm_pkg::ADDR_CONTROL, 16'h6EBF);
        rd(sgm_pkg::ADDR_CONTROL, 16'h4D60);
        chk("outputs", 16'h0166, outs);
        wr(sgm_pkg::ADDR_CONTROL, 16'h0000);
        rd(sgm_pkg::ADDR_CONTROL, 16'h0940);
        chk("outputs", 16'h0042, outs);
        wr(sgm_pkg::ADDR_CONTROL, 16'h8000);
        rd(sgm_pkg::ADDR_CONTROL, 16'h1540);
        $display("test control done");
        wr(sgm_pkg::ADDR_EXT_STATUS, 16'h0000);
        rd(sgm_pkg::ADDR_EXT_STATUS, 16'h8000);
        foreach (unmapped[i]) begin
            wr(unmapped[i], 16'hFFFF);
            rd(unmapped[i], 16'h0000);
        end
        rd(sgm_pkg::ADDR_ID_HI, ID_HI);
        rd(sgm_pkg::ADDR_ID_LO, ID_LO);
        rd(sgm_pkg::ADDR_CONTROL, 16'h1540);
        $display("test map done");
        phy_sel = PHY2;
        rd(sgm_pkg::ADDR_CONTROL, 16'h1540);
        wr(sgm_pkg::ADDR_CONTROL, 16'h6EBF);
        rd(sgm_pkg::ADDR_CONTROL, 16'h6D20);
        chk("outputs", 16'h00A5, outs2);
        wr(sgm_pkg::ADDR_CONTROL, 16'h0000);
        rd(sgm_pkg::ADDR_CONTROL, 16'h0900);
        chk("outputs", 16'h0000, outs2);
        wr(sgm_pkg::ADDR_CONTROL, 16'h8000);
        rd(sgm_pkg::ADDR_CONTROL, 16'h1540);
        phy_sel = PHY;
        rd(sgm_pkg::ADDR_CONTROL, 16'h1540);
        $display("test mac mode build done");
        link_up = 1'h1;
        an_complete = 1'h1;
        rd(sgm_pkg::ADDR_STATUS, 16'h01E8);
        rd(sgm_pkg::ADDR_STATUS, 16'h01EC);
        link_up = 1'h0;
        repeat (8) @(negedge clk);
        link_up = 1'h1;
        repeat (8) @(negedge clk);
        rd(sgm_pkg::ADDR_STATUS, 16'h01E8);
        rd(sgm_pkg::ADDR_STATUS, 16'h01EC);
        $display("test link done");
        cfg_vector = 16'h0020;
        cfg_valid = 1'h1;
        @(negedge clk);
        cfg_valid = 1'h0;
        rd(sgm_pkg::ADDR_CONTROL, 16'h0160);
        chk("outputs", 16'h0006, outs);
        chk("outputs", 16'h0004, outs2);
        rst = 1'h1;
        repeat (4) @(negedge clk);
        rst = 1'h0;
        repeat (8) @(negedge clk);
        rd(sgm_pkg::ADDR_CONTROL, 16'h1540);
        cfg_valid = 1'h1;
        @(negedge clk);
        cfg_valid = 1'h0;
        @(negedge clk);
        chk("outputs", 16'h0006, outs);
        locked = 1'h0;
        repeat (6) @(negedge clk);
        locked = 1'h1;
        repeat (8) @(negedge clk);
        rd(sgm_pkg::ADDR_CONTROL, 16'h1540);
        $display("test config and lock done");
        tally_and_finish;
    end
endmodule : sgm_mgmt_regs_tb
`default_nettype wire
